// ===== inc/kef_cfg.svh
// Register map, field positions, reset values and timing for the event queue
`ifndef KEF_CFG_SVH
`define KEF_CFG_SVH

`define KEF_ADDR_CFG    8'h01
`define KEF_ADDR_STAT   8'h02
`define KEF_ADDR_CNT    8'h03
`define KEF_ADDR_QFIRST 8'h04
`define KEF_ADDR_QLAST  8'h0d
`define KEF_ADDR_TMR    8'h0e
`define KEF_ADDR_KEY1   8'h0f
`define KEF_ADDR_KEY2   8'h10

`define KEF_CFG_EVT_IEN   0
`define KEF_CFG_KLK_IEN   2
`define KEF_CFG_OVF_IEN   3
`define KEF_CFG_INT_PULSE 4
`define KEF_CFG_OVF_MODE  5
`define KEF_CFG_AUTOINC   7

`define KEF_ST_EVT 0
`define KEF_ST_KLK 2
`define KEF_ST_OVF 3

`define KEF_CNT_FIRST_UNLOCK_OK  4
`define KEF_CNT_SECOND_UNLOCK_OK  5
`define KEF_CNT_LCKEN 6

`define KEF_TMR_LSB 3

`define KEF_RST_BYTE 8'h00
`define KEF_FIFO_DEPTH 10

`define KEF_CLK_HZ  20000000
`define KEF_TICK_MS 1000
`define KEF_REL_US  275

`endif

// ===== inc/kef_pkg.sv
// Types shared by the event queue and lock logic
package kef_pkg;
    typedef struct packed {
        logic       press;
        logic       gpi;
        logic [6:0] gpi_num;
        logic [2:0] row;
        logic [3:0] col;
    } kef_key_s;

    typedef struct packed {
        logic       press;
        logic [6:0] num;
    } kef_event_s;

    typedef enum logic [1:0] {
        LK_IDLE,
        LK_WAIT1,
        LK_WAIT2
    } kef_lock_e;
endpackage

// ===== hdl/kef_top.sv
// Key event queue with overflow handling, keypad lock and host interrupt
`timescale 1ns/1ps
`include "kef_cfg.svh"

module kef_top #(
    parameter int DEPTH       = `KEF_FIFO_DEPTH,
    parameter int TICK_CYCLES = `KEF_TICK_MS * (`KEF_CLK_HZ / 1000),
    parameter int REL_CYCLES  = `KEF_REL_US * (`KEF_CLK_HZ / 1000000)
) (
    // Clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    // Event source
    input  wire logic              evt_valid_in,
    input  wire kef_pkg::kef_key_s key_in,
    // Byte register port
    input  wire logic              addr_load_in,
    input  wire logic [7:0]        addr_in,
    input  wire logic              wr_in,
    input  wire logic [7:0]        wr_data_in,
    input  wire logic              rd_in,
    output logic [7:0]             rd_data_out,
    output logic                   rd_valid_out,
    // Open-drain interrupt pin
    output logic                   int_drv_out,
    output logic                   int_oe_n_out
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int RW = $clog2(REL_CYCLES + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    kef_pkg::kef_event_s fifo [DEPTH];
    logic [PW-1:0]       head;
    logic [PW-1:0]       tail;
    logic [CW-1:0]       count;
    logic [7:0]          ptr;
    logic [7:0]          cfg;
    logic [7:0]          tmr;
    logic [7:0]          key1;
    logic [7:0]          key2;
    logic                evt_flag;
    logic                klk_flag;
    logic                ovf_flag;
    logic                first_unlock_ok;
    logic                second_unlock_ok;
    logic                lock_en;
    kef_pkg::kef_lock_e  lk_state;
    logic [4:0]          secs;
    logic [TW-1:0]       tick;
    logic [RW-1:0]       rel;

    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // Event number and byte
    logic [6:0]          mtx_num;
    kef_pkg::kef_event_s new_evt;
    assign mtx_num = 7'(key_in.row) * 7'd10 + 7'(key_in.col) + 7'd1;
    assign new_evt = {key_in.press, (key_in.gpi ? key_in.gpi_num : mtx_num)};

    // Register access decode
    logic q_sel;
    logic rd_q;
    logic wr_stat;
    assign q_sel   = (ptr >= `KEF_ADDR_QFIRST) && (ptr <= `KEF_ADDR_QLAST);
    assign rd_q    = rd_in && q_sel;
    assign wr_stat = wr_in && (ptr == `KEF_ADDR_STAT);

    // Queue control
    logic full;
    logic empty;
    logic rec;
    logic pop;
    logic push;
    logic ovw;
    assign full  = (count == FULL_CNT);
    assign empty = (count == '0);
    assign rec   = evt_valid_in && !lock_en;
    assign pop   = rd_q && !empty;
    assign ovw   = rec && full && !pop && cfg[`KEF_CFG_OVF_MODE];
    assign push  = rec && (!full || pop || ovw);

    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            fifo[tail] <= new_evt;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            head  <= '0;
            tail  <= '0;
            count <= '0;
        end else begin
            if (push) begin
                tail <= step(tail);
            end
            if (pop || ovw) begin
                head <= step(head);
            end
            if (push && !pop && !full) begin
                count <= count + CW'(1);
            end else if (pop && !push) begin
                count <= count - CW'(1);
            end
        end
    end

    // Lock match and timer
    logic lk_press;
    logic hit1;
    logic hit2;
    logic tmr_on;
    logic expire;
    logic unlock;
    logic first_irq;
    assign lk_press  = evt_valid_in && lock_en && key_in.press;
    assign hit1      = lk_press && (new_evt.num == key1[6:0]);
    assign hit2      = lk_press && (new_evt.num == key2[6:0]);
    assign tmr_on    = (tmr[7:`KEF_TMR_LSB] != 5'h00);
    assign expire    = tmr_on && (lk_state != kef_pkg::LK_IDLE)
                     && (secs == 5'h00) && (tick == '0);
    assign unlock    = (lk_state == kef_pkg::LK_WAIT2) && hit2 && !expire;
    assign first_irq = (lk_state == kef_pkg::LK_IDLE) && lk_press && tmr_on;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lk_state <= kef_pkg::LK_IDLE;
        end else if (!lock_en || expire || unlock) begin
            lk_state <= kef_pkg::LK_IDLE;
        end else if (lk_press) begin
            unique case (lk_state)
                kef_pkg::LK_IDLE: begin
                    lk_state <= hit1 ? kef_pkg::LK_WAIT2 : kef_pkg::LK_WAIT1;
                end
                kef_pkg::LK_WAIT1: begin
                    lk_state <= hit1 ? kef_pkg::LK_WAIT2 : kef_pkg::LK_WAIT1;
                end
                kef_pkg::LK_WAIT2: begin
                    lk_state <= kef_pkg::LK_WAIT1;
                end
            endcase
        end
    end

    // Mask timer counts whole seconds from the first locked press
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            secs <= 5'h00;
            tick <= '0;
        end else if (lk_state == kef_pkg::LK_IDLE) begin
            secs <= tmr[7:`KEF_TMR_LSB] - 5'h01;
            tick <= TW'(TICK_CYCLES - 1);
        end else if (tick != '0) begin
            tick <= tick - TW'(1);
        end else if (secs != 5'h00) begin
            secs <= secs - 5'h01;
            tick <= TW'(TICK_CYCLES - 1);
        end
    end

    // Lock enable and progress bits; hardware clear on unlock wins
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lock_en <= 1'b0;
            first_unlock_ok    <= 1'b0;
            second_unlock_ok    <= 1'b0;
        end else begin
            if (unlock) begin
                lock_en <= 1'b0;
            end else if (wr_in && ptr == `KEF_ADDR_CNT) begin
                lock_en <= wr_data_in[`KEF_CNT_LCKEN];
            end
            if (wr_in && ptr == `KEF_ADDR_CNT && wr_data_in[`KEF_CNT_LCKEN]) begin
                first_unlock_ok <= 1'b0;
                second_unlock_ok <= 1'b0;
            end else if (expire) begin
                first_unlock_ok <= 1'b0;
                second_unlock_ok <= 1'b0;
            end else if (unlock) begin
                second_unlock_ok <= 1'b1;
            end else if (lk_press && lk_state != kef_pkg::LK_WAIT2) begin
                first_unlock_ok <= hit1;
            end else if (lk_press) begin
                first_unlock_ok <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg  <= `KEF_RST_BYTE;
            tmr  <= `KEF_RST_BYTE;
            key1 <= `KEF_RST_BYTE;
            key2 <= `KEF_RST_BYTE;
        end else if (wr_in) begin
            if (ptr == `KEF_ADDR_CFG) begin
                cfg <= wr_data_in;
            end
            if (ptr == `KEF_ADDR_TMR) begin
                tmr <= wr_data_in;
            end
            if (ptr == `KEF_ADDR_KEY1) begin
                key1 <= wr_data_in;
            end
            if (ptr == `KEF_ADDR_KEY2) begin
                key2 <= wr_data_in;
            end
        end
    end

    // Status flags: a set in the same cycle as a clear wins
    logic evt_set;
    assign evt_set = push || first_irq;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            evt_flag <= 1'b0;
            klk_flag <= 1'b0;
            ovf_flag <= 1'b0;
        end else begin
            if (evt_set) begin
                evt_flag <= 1'b1;
            end else if (wr_stat && wr_data_in[`KEF_ST_EVT] && empty) begin
                evt_flag <= 1'b0;
            end
            if (unlock) begin
                klk_flag <= 1'b1;
            end else if (wr_stat && wr_data_in[`KEF_ST_KLK]) begin
                klk_flag <= 1'b0;
            end
            if (rec && full) begin
                ovf_flag <= 1'b1;
            end else if (wr_stat && wr_data_in[`KEF_ST_OVF]) begin
                ovf_flag <= 1'b0;
            end
        end
    end

    // Interrupt pin, with optional release window on a refused clear
    logic irq_req;
    assign irq_req = (evt_flag && cfg[`KEF_CFG_EVT_IEN])
                   || (ovf_flag && cfg[`KEF_CFG_OVF_IEN])
                   || (klk_flag && cfg[`KEF_CFG_KLK_IEN]);

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rel <= '0;
        end else if (wr_stat && wr_data_in[`KEF_ST_EVT] && !empty
                     && cfg[`KEF_CFG_INT_PULSE] && int_drv_out) begin
            rel <= RW'(REL_CYCLES);
        end else if (rel != '0) begin
            rel <= rel - RW'(1);
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            int_drv_out  <= 1'b0;
            int_oe_n_out <= 1'b1;
        end else begin
            int_drv_out  <= irq_req && (rel == '0);
            int_oe_n_out <= !(irq_req && (rel == '0));
        end
    end

    // Register pointer and read data
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ptr <= `KEF_RST_BYTE;
        end else if (addr_load_in) begin
            ptr <= addr_in;
        end else if (rd_in && cfg[`KEF_CFG_AUTOINC]) begin
            ptr <= ptr + 8'h01;
        end
    end

    logic [7:0] next_rd;
    always_comb begin
        next_rd = 8'h00;
        if (q_sel) begin
            next_rd = empty ? 8'h00 : fifo[head];
        end else begin
            unique case (ptr)
                `KEF_ADDR_CFG:  next_rd = cfg;
                `KEF_ADDR_STAT: next_rd = {4'h0, ovf_flag, klk_flag, 1'b0, evt_flag};
                `KEF_ADDR_CNT:  next_rd = {1'b0, lock_en, second_unlock_ok, first_unlock_ok, 4'(count)};
                `KEF_ADDR_TMR:  next_rd = tmr;
                `KEF_ADDR_KEY1: next_rd = key1;
                `KEF_ADDR_KEY2: next_rd = key2;
                default:        next_rd = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out  <= 8'h00;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_in;
            if (rd_in) begin
                rd_data_out <= next_rd;
            end
        end
    end

    // Checks
    chk_count_limit: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        count <= FULL_CNT) else $error("pending count above depth");

    chk_push_count: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (push && !pop && !full) |=> count == $past(count) + CW'(1))
        else $error("count did not rise on push");

    chk_empty_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (rd_q && empty) |=> rd_valid_out && rd_data_out == 8'h00)
        else $error("empty queue read not zero");

    chk_ovf_set: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (rec && full) |=> ovf_flag) else $error("overflow flag missed");

    chk_ovw_sat: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        ovw |=> count == FULL_CNT && head == step($past(head)))
        else $error("overwrite did not keep full");

    chk_drop_mode: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (rec && full && !pop && !cfg[`KEF_CFG_OVF_MODE]) |=> $stable(tail))
        else $error("event stored while full in drop mode");

    chk_flag_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (evt_flag && !empty) |=> evt_flag) else $error("event flag cleared early");

    chk_lock_block: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (evt_valid_in && lock_en && !rd_in) |=> $stable(tail) && $stable(count))
        else $error("event recorded while locked");

    chk_irq_drive: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (ovf_flag && cfg[`KEF_CFG_OVF_IEN] && rel == '0) |=> int_drv_out && !int_oe_n_out)
        else $error("overflow interrupt not driven");

    chk_klk_mask: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (klk_flag && !cfg[`KEF_CFG_KLK_IEN] && !evt_flag && !ovf_flag) |=> !int_drv_out)
        else $error("masked keylock flag drove pin");

    chk_expire_idle: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        expire |=> lk_state == kef_pkg::LK_IDLE && !first_unlock_ok && !second_unlock_ok)
        else $error("lock machine not reset on expiry");

    chk_autoinc: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (rd_in && !addr_load_in && cfg[`KEF_CFG_AUTOINC]) |=> ptr == $past(ptr) + 8'h01)
        else $error("pointer did not advance");
endmodule

// ===== dv/kef_host_model.sv
// Host side of the open-drain interrupt line: pull-up and assertion counter
`timescale 1ns/1ps

module kef_host_model (
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rst_n_in,
    // Interrupt pin enable from the device
    input  wire logic       int_oe_n_in,
    // Host view of the line
    output logic            int_n_out,
    output logic [7:0]      irq_cnt_out
);
    logic int_n_q;

    // The board pull-up holds the line high whenever the device lets go
    assign int_n_out = int_oe_n_in ? 1'b1 : 1'b0;

    // Counts falling edges only, as an edge-triggered host would see them
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            int_n_q     <= 1'b1;
            irq_cnt_out <= 8'h00;
        end else begin
            int_n_q <= int_n_out;
            if (int_n_q && !int_n_out) begin
                irq_cnt_out <= irq_cnt_out + 8'h01;
            end
        end
    end
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the key event queue, lock logic and interrupt pin
`timescale 1ns/1ps
`include "kef_cfg.svh"

module tb_top;
    logic              clk;
    logic              rst_n;
    logic              evt_valid;
    kef_pkg::kef_key_s key;
    logic              addr_load;
    logic [7:0]        addr;
    logic              wr;
    logic [7:0]        wr_data;
    logic              rd;
    logic [7:0]        rd_data;
    logic              rd_valid;
    logic              int_drv;
    logic              int_oe_n;
    logic              int_n;
    logic [7:0]        irq_cnt;
    logic [7:0]        irq_base;
    int                err_total;
    int                cmp_count;
    int                k;

    // Short tick and release window keep the timer tests to a few dozen cycles
    kef_top #(.DEPTH(10), .TICK_CYCLES(20), .REL_CYCLES(8)) i_kef_top (
        .ref_clk_in(clk), .rst_n_in(rst_n), .evt_valid_in(evt_valid), .key_in(key),
        .addr_load_in(addr_load), .addr_in(addr), .wr_in(wr), .wr_data_in(wr_data),
        .rd_in(rd), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .int_drv_out(int_drv), .int_oe_n_out(int_oe_n)
    );

    kef_host_model i_kef_host_model (
        .ref_clk_in(clk), .rst_n_in(rst_n), .int_oe_n_in(int_oe_n),
        .int_n_out(int_n), .irq_cnt_out(irq_cnt)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic load(input logic [7:0] a);
        @(posedge clk);
        addr_load <= 1'b1;
        addr      <= a;
        @(posedge clk);
        addr_load <= 1'b0;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        load(a);
        wr      <= 1'b1;
        wr_data <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Reads at the current pointer; the pointer moves only if auto-increment is on
    task automatic rnext(input logic [7:0] exp, input string name, input logic [7:0] m = 8'hff);
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check({name, " valid"}, {7'h00, rd_valid}, 8'h01);
        check(name, rd_data & m, exp);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string name,
                       input logic [7:0] m = 8'hff);
        load(a);
        rnext(exp, name, m);
    endtask

    // Matrix key n is sent as row and column, so the device must rebuild the number;
    // numbers above 80 go out as input events carrying their own number
    task automatic ev(input logic p, input int n);
        @(posedge clk);
        evt_valid   <= 1'b1;
        key.press   <= p;
        key.gpi     <= (n > 80);
        key.gpi_num <= 7'(n);
        key.row     <= 3'((n - 1) / 10);
        key.col     <= 4'((n - 1) % 10);
        @(posedge clk);
        evt_valid <= 1'b0;
    endtask

    task automatic pinchk(input logic exp, input string name);
        repeat (3) @(posedge clk);
        #1;
        check(name, {7'h00, int_n}, {7'h00, exp});
        check({name, " drive"}, {7'h00, int_drv}, {7'h00, !exp});
    endtask

    task automatic done(input string t);
        $display("Test %s finished, %0d mismatches so far", t, err_total);
    endtask

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clk);
        err_total++;
        print_verdict();
    end

    initial begin
        rst_n     = 1'b0;
        evt_valid = 1'b0;
        key       = '0;
        addr_load = 1'b0;
        addr      = 8'h00;
        wr        = 1'b0;
        wr_data   = 8'h00;
        rd        = 1'b0;
        err_total = 0;
        cmp_count = 0;
        irq_base  = 8'h00;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;

        rdc(`KEF_ADDR_CFG, 8'h00, "cfg reset");
        rdc(`KEF_ADDR_STAT, 8'h00, "status reset");
        rdc(`KEF_ADDR_CNT, 8'h00, "count reset");
        rdc(`KEF_ADDR_QFIRST, 8'h00, "empty queue");
        wreg(8'h20, 8'h5a);
        rdc(8'h20, 8'h00, "unmapped");
        wreg(`KEF_ADDR_KEY1, 8'h05);
        rdc(`KEF_ADDR_KEY1, 8'h05, "unlock key one");
        done("reset");

        wreg(`KEF_ADDR_CFG, 8'h81);
        ev(1'b1, 1);
        ev(1'b1, 12);
        ev(1'b0, 1);
        ev(1'b1, 80);
        ev(1'b0, 80);
        ev(1'b0, 97);
        pinchk(1'b0, "int on events");
        rdc(`KEF_ADDR_STAT, 8'h01, "event flag");
        wreg(`KEF_ADDR_STAT, 8'h01);
        rdc(`KEF_ADDR_STAT, 8'h01, "flag held");
        pinchk(1'b0, "int held");
        rdc(`KEF_ADDR_CNT, 8'h06, "pending count");
        load(`KEF_ADDR_QFIRST);
        rnext(8'h81, "press 1");
        rnext(8'h8c, "press 12");
        rnext(8'h01, "release 1");
        rnext(8'hd0, "press 80");
        rnext(8'h50, "release 80");
        rnext(8'h61, "input release");
        rnext(8'h00, "drained at 0x0a");
        rdc(`KEF_ADDR_CNT, 8'h00, "count reread");
        wreg(`KEF_ADDR_STAT, 8'h01);
        rdc(`KEF_ADDR_STAT, 8'h00, "flag cleared");
        pinchk(1'b1, "int released");
        done("queue order");

        wreg(`KEF_ADDR_CFG, 8'h11);
        ev(1'b1, 3);
        pinchk(1'b0, "int before pulse");
        wreg(`KEF_ADDR_STAT, 8'h01);
        pinchk(1'b1, "int pulse gap");
        repeat (8) @(posedge clk);
        pinchk(1'b0, "int back");
        rdc(`KEF_ADDR_QFIRST, 8'h83, "pulse event");
        wreg(`KEF_ADDR_STAT, 8'h01);
        done("pulse");

        wreg(`KEF_ADDR_CFG, 8'h08);
        for (k = 1; k <= 11; k++) ev(1'b1, k);
        pinchk(1'b0, "int overflow");
        rdc(`KEF_ADDR_CNT, 8'h0a, "count full");
        rdc(`KEF_ADDR_STAT, 8'h09, "overflow flag");
        load(`KEF_ADDR_QFIRST);
        for (k = 1; k <= 10; k++) rnext(8'h80 | 8'(k), "drop mode");
        rnext(8'h00, "drop drained");
        wreg(`KEF_ADDR_STAT, 8'h09);
        done("overflow drop");

        wreg(`KEF_ADDR_CFG, 8'h20);
        for (k = 1; k <= 12; k++) ev(1'b1, k);
        pinchk(1'b1, "overflow irq off");
        rdc(`KEF_ADDR_CNT, 8'h0a, "count saturated");
        rdc(`KEF_ADDR_STAT, 8'h09, "overflow flag");
        load(`KEF_ADDR_QFIRST);
        for (k = 3; k <= 12; k++) rnext(8'h80 | 8'(k), "overwrite mode");
        wreg(`KEF_ADDR_STAT, 8'h09);
        done("overflow overwrite");

        wreg(`KEF_ADDR_KEY2, 8'h07);
        wreg(`KEF_ADDR_CFG, 8'h05);
        wreg(`KEF_ADDR_TMR, 8'h00);
        wreg(`KEF_ADDR_CNT, 8'h40);
        ev(1'b1, 5);
        rdc(`KEF_ADDR_CNT, 8'h50, "first key ok");
        rdc(`KEF_ADDR_STAT, 8'h00, "no first irq");
        ev(1'b1, 7);
        rdc(`KEF_ADDR_STAT, 8'h04, "keylock flag");
        rdc(`KEF_ADDR_CNT, 8'h20, "unlocked", 8'h6f);
        pinchk(1'b0, "int keylock");
        wreg(`KEF_ADDR_CFG, 8'h01);
        pinchk(1'b1, "keylock masked");
        wreg(`KEF_ADDR_CFG, 8'h05);
        pinchk(1'b0, "keylock unmasked");
        wreg(`KEF_ADDR_STAT, 8'h04);
        pinchk(1'b1, "keylock cleared");
        done("lock without timer");

        wreg(`KEF_ADDR_TMR, 8'h08);
        wreg(`KEF_ADDR_CNT, 8'h40);
        irq_base = irq_cnt;
        ev(1'b1, 9);
        pinchk(1'b0, "first press irq");
        rdc(`KEF_ADDR_CNT, 8'h40, "locked not queued");
        wreg(`KEF_ADDR_STAT, 8'h01);
        ev(1'b1, 9);
        pinchk(1'b1, "no second irq");
        check("irq count", irq_cnt - irq_base, 8'h01);
        // One timer unit is 20 cycles here; wait well past it
        repeat (40) @(posedge clk);
        ev(1'b1, 9);
        pinchk(1'b0, "irq after expiry");
        rdc(`KEF_ADDR_STAT, 8'h01, "flag after expiry");
        done("lock with timer");

        // Reset in mid-run while locked with a flag and the pin asserted
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`KEF_ADDR_CNT, 8'h00, "count after reset");
        rdc(`KEF_ADDR_STAT, 8'h00, "status after reset");
        rdc(`KEF_ADDR_CFG, 8'h00, "cfg after reset");
        pinchk(1'b1, "int after reset");
        done("mid-run reset");

        print_verdict();
    end
endmodule
